// ### rtl/dnp_defs.svh
`ifndef DNP_DEFS_SVH
`define DNP_DEFS_SVH

// pulse timing
`define DNP_CLK_HZ 125000000
`define DNP_PULSE_MS 30
`define DNP_PULSE_CYC ((`DNP_CLK_HZ / 1000) * `DNP_PULSE_MS)

// event log source codes
`define DNP_SRC_W 2
`define DNP_SRC_NONE 2'h0
`define DNP_SRC_PANEL 2'h1

`endif

// ### rtl/dnp_pkg.sv
package dnp_pkg;
    typedef enum logic [1:0] {
        DNP_IDLE = 2'b00,
        DNP_PULSE = 2'b01,
        DNP_LOCKED = 2'b11
    } dnp_state_t;
endpackage

// ### rtl/dnp_sync.sv
module dnp_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_r;

    // refused at elaboration: an empty synchroniser would leave its output undriven
    if (WIDTH < 1) begin : g_width_check
        $error("dnp_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            syncOut <= '0;
        end else begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule

// ### rtl/dnp_nmi_gen.sv
// Overview of operation
// - each interrupt pulse to the host stays high at least 30 ms
// - after one pulse, no further pulses until system reset or power-down
// - chassis command triggers a pulse and logs no event
// - front panel button press triggers a pulse unless locked out
// - watchdog pre-timeout triggers a pulse only when its action selects the interrupt
// - only the button trigger records a front panel sensor event
`include "dnp_defs.svh"

module dnp_nmi_gen #(
    parameter int PULSE_CYC = `DNP_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chassisPulseReq,
    input wire logic panelButton,
    input wire logic wdtPreTimeout,
    input wire logic wdtActionNmi,
    input wire logic sysReset,
    input wire logic powerDown,
    output logic hostNmi,
    output logic nmiLocked,
    output logic panelEventValid,
    output logic [`DNP_SRC_W-1:0] panelEventSrc
);
    import dnp_pkg::*;

    localparam int CNT_W = $clog2(PULSE_CYC + 1);

    // the counter is loaded with PULSE_CYC - 1, so a zero width cannot be served
    if (PULSE_CYC < 1) begin : g_cyc_check
        $error("dnp_nmi_gen: PULSE_CYC must be at least 1");
    end

    logic [1:0] pinSync;
    logic panelLvl;
    logic resetLvl;
    logic panelPrev_r;
    logic panelPress;
    logic trigAny;
    logic clearLock;
    logic [CNT_W-1:0] cnt_r;
    dnp_state_t state_r;

    // button and system reset come from pins
    dnp_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .asyncIn({panelButton, sysReset}),
        .syncOut(pinSync)
    );

    assign panelLvl = pinSync[1];
    assign resetLvl = pinSync[0];
    assign clearLock = resetLvl | powerDown;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            panelPrev_r <= 1'b0;
        end else begin
            panelPrev_r <= panelLvl;
        end
    end

    assign panelPress = panelLvl & ~panelPrev_r;
    // watchdog only counts when its action picks the interrupt
    assign trigAny = chassisPulseReq | panelPress | (wdtPreTimeout & wdtActionNmi);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= DNP_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                DNP_IDLE: begin
                    if (!clearLock && trigAny) begin
                        state_r <= DNP_PULSE;
                        cnt_r <= CNT_W'(PULSE_CYC - 1);
                    end
                end
                DNP_PULSE: begin
                    // the pulse runs to full width even if a reset arrives mid-pulse
                    if (cnt_r == '0) begin
                        state_r <= DNP_LOCKED;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                DNP_LOCKED: begin
                    if (clearLock) begin
                        state_r <= DNP_IDLE;
                    end
                end
                default: begin
                    state_r <= DNP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hostNmi <= 1'b0;
            nmiLocked <= 1'b0;
        end else begin
            hostNmi <= (state_r == DNP_PULSE);
            nmiLocked <= (state_r != DNP_IDLE);
        end
    end

    // event only when the button itself started the pulse
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            panelEventValid <= 1'b0;
            panelEventSrc <= `DNP_SRC_NONE;
        end else begin
            panelEventValid <= (state_r == DNP_IDLE) && !clearLock && panelPress;
            panelEventSrc <= ((state_r == DNP_IDLE) && !clearLock && panelPress) ? `DNP_SRC_PANEL : `DNP_SRC_NONE;
        end
    end

    // helper: cycles hostNmi has been high
    logic [CNT_W:0] hiCnt_r;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hiCnt_r <= '0;
        end else if (hostNmi) begin
            hiCnt_r <= hiCnt_r + 1'b1;
        end else begin
            hiCnt_r <= '0;
        end
    end

    sequence seqStart;
        (state_r == DNP_IDLE) && !clearLock && trigAny;
    endsequence

    sequence seqPulseOn;
        ##2 hostNmi;
    endsequence

    // lockout with no clear pending: triggers here must be dropped
    sequence seqLockedQuiet;
        (state_r == DNP_LOCKED) && !clearLock;
    endsequence

    // hostNmi lags the state by one cycle, so two quiet cycles are checked
    sequence seqNoPulse;
        !hostNmi ##1 !hostNmi;
    endsequence

    // hiCnt_r already holds the full count at the edge where the fall is seen
    chk_pulse_min_width: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(hostNmi) |-> hiCnt_r == (CNT_W + 1)'(PULSE_CYC))
        else $error("nmi pulse width wrong");

    chk_pulse_full: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_PULSE) && cnt_r != '0 |=> state_r == DNP_PULSE)
        else $error("pulse cut short");

    chk_locked_no_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
        seqLockedQuiet and trigAny |=> seqNoPulse)
        else $error("pulse issued during lockout");

    chk_lock_covers_nmi: assert property (@(posedge core_clk) disable iff (!nrst)
        hostNmi |-> nmiLocked)
        else $error("pulse without lock flag");

    chk_release_unlock: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_LOCKED) && clearLock |=> state_r == DNP_IDLE ##1 !nmiLocked)
        else $error("lockout not released by clear");

    chk_chassis_starts: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && !clearLock && chassisPulseReq |=> state_r == DNP_PULSE)
        else $error("chassis command did not start pulse");

    chk_wdt_starts: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && !clearLock && wdtPreTimeout && wdtActionNmi |=> state_r == DNP_PULSE)
        else $error("watchdog expiry did not start pulse");

    chk_event_single: assert property (@(posedge core_clk) disable iff (!nrst)
        panelEventValid |=> !panelEventValid)
        else $error("event request longer than one cycle");

    chk_src_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        !panelEventValid |-> panelEventSrc == `DNP_SRC_NONE)
        else $error("event source without request");

    chk_clear_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && clearLock |=> state_r == DNP_IDLE && !panelEventValid)
        else $error("trigger taken while clear active");

    chk_lockout_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_LOCKED) && !clearLock |=> state_r == DNP_LOCKED)
        else $error("lockout released without reset");

    chk_trigger_starts: assert property (@(posedge core_clk) disable iff (!nrst)
        seqStart |-> seqPulseOn)
        else $error("trigger did not start pulse");

    chk_chassis_nolog: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && chassisPulseReq && !panelPress |=> !panelEventValid)
        else $error("chassis command logged an event");

    chk_wdt_gated: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && !clearLock && wdtPreTimeout && !wdtActionNmi && !chassisPulseReq && !panelPress
        |=> state_r == DNP_IDLE)
        else $error("watchdog fired without interrupt action");

    chk_panel_logs: assert property (@(posedge core_clk) disable iff (!nrst)
        seqStart and panelPress |=> panelEventValid && panelEventSrc == `DNP_SRC_PANEL)
        else $error("button press not logged");

    chk_panel_starts: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_IDLE) && !clearLock && panelPress |=> state_r == DNP_PULSE)
        else $error("button press did not start pulse");

    chk_no_retrigger: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == DNP_PULSE) && trigAny && cnt_r != '0 |=> state_r == DNP_PULSE && !panelEventValid)
        else $error("trigger during pulse was acted on");
endmodule

// ### dv/dnp_host_model.sv
module dnp_host_model (
    input wire logic core_clk,
    input wire logic hostNmi,
    output logic pulseDone,
    output logic [31:0] pulseWidth
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] highCnt = 0;
    // the host only sees a pulse once it falls, so the width is judged at release
    always @(posedge core_clk) begin
        pulseDone <= 1'b0;
        if (hostNmi === 1'b1) begin
            highCnt <= highCnt + 1;
        end else if (highCnt != 0) begin
            pulseDone <= 1'b1;
            pulseWidth <= highCnt;
            highCnt <= 0;
        end
    end
endmodule

// ### dv/dnp_nmi_gen_tb.sv
module dnp_nmi_gen_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 20;
    logic core_clk = 0, nrst = 0, chassisPulseReq = 0, panelButton = 0, wdtPreTimeout = 0;
    logic wdtActionNmi = 0, sysReset = 0, powerDown = 0, evSeen = 0;
    logic hostNmi, nmiLocked, panelEventValid, pulseDone;
    logic [1:0] panelEventSrc;
    logic [31:0] pulseWidth;
    int miscompares = 0, checks_done = 0, seed = 32'h5fbad141;
    bit noteQ[$];
    always #4 core_clk = ~core_clk;
    dnp_nmi_gen #(.PULSE_CYC(PC)) dut_u (.core_clk(core_clk), .nrst(nrst), .chassisPulseReq(chassisPulseReq),
        .panelButton(panelButton), .wdtPreTimeout(wdtPreTimeout), .wdtActionNmi(wdtActionNmi), .sysReset(sysReset),
        .powerDown(powerDown), .hostNmi(hostNmi), .nmiLocked(nmiLocked), .panelEventValid(panelEventValid),
        .panelEventSrc(panelEventSrc));
    dnp_host_model host_u (.core_clk(core_clk), .hostNmi(hostNmi), .pulseDone(pulseDone), .pulseWidth(pulseWidth));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (checks_done > 0 && miscompares == 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // 0 chassis, 1 button, 2 and 3 watchdog; the button is held so the synchroniser sees it
    task automatic fire(int k);
        if (k == 0) chassisPulseReq <= 1'b1;
        if (k == 1) panelButton <= 1'b1;
        if (k > 1) wdtPreTimeout <= 1'b1;
        @(posedge core_clk);
        chassisPulseReq <= 1'b0;
        wdtPreTimeout <= 1'b0;
        tick(3);
        panelButton <= 1'b0;
    endtask
    always @(posedge core_clk) begin
        if (panelEventValid === 1'b1) begin
            evSeen <= 1'b1;
            check("event src", panelEventSrc, 1);
        end else if (nrst) begin
            check("idle src", panelEventSrc, 0);
        end
        if (pulseDone === 1'b1) begin
            if (noteQ.size() == 0) check("extra pulse", 1, 0);
            else begin
                check("pulse width", pulseWidth, PC);
                check("event logged", evSeen, noteQ.pop_front());
            end
            evSeen <= 1'b0;
        end
    end
    initial begin
        tick(8);
        nrst <= 1'b1;
        tick(2);
        for (int k = 0; k < 4; k++) begin
            wdtActionNmi <= (k == 2);
            if (k < 3) noteQ.push_back(k == 1);
            fire(k);
            tick(2 + $unsigned($random(seed)) % 8);
            fire(k);
            tick(PC + 10);
            fire(k);
            check("locked", nmiLocked, k < 3);
            // alternate so both the pin reset and the power-down clear are exercised
            if (k % 2 == 1) sysReset <= 1'b1;
            else powerDown <= 1'b1;
            tick(3);
            fire(k);
            sysReset <= 1'b0;
            powerDown <= 1'b0;
            tick(6);
            check("cleared", nmiLocked, 0);
        end
        tick(PC);
        check("pulses missing", noteQ.size(), 0);
        close_out();
    end
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule
